// file: logic/dbp_slave.sv
// debug bus slave port with a small word register file
//
// Behaviour
// - all transfers timed on rising clock edge
// - low reset returns port to idle
// - word address carried on bits 31..2
// - master drives one select per slave
// - enable only in access cycles
// - write high, read low, whole transfer
// - master drives write data, slave stores
// - only selected slave drives read data
// - ready held low while waiting
// - error given in access cycle
// - error only when component unavailable
// - powered down: ready 1, err 1, rdata 0
// - data path is 32 bits, full words
// - bit 31 tells internal from external
// - registers also reachable by side port
// - non-pipelined, stalls and error responses
// - address bits 1..0 not needed
`timescale 1ns/100ps
`default_nettype none
module dbp_slave (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    dbp_if.slave             bus,
    input  wire logic        pwr_down_i,
    input  wire logic        comp_disable_i,
    input  wire logic        side_we_i,
    input  wire logic [3:0]  side_idx_i,
    input  wire logic [31:0] side_wdata_i,
    output logic      [31:0] side_rdata_o,
    output logic             ext_access_o,
    output logic             lock_hit_o,
    input  wire logic        lock_en_i
);
    // ************************************************
    // synchronised status levels
    // ************************************************
    logic [1:0] pd_sync;
    logic [1:0] dis_sync;
    logic [1:0] lock_sync;
    logic       unavail;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pd_sync   <= 2'h0;
            dis_sync  <= 2'h0;
            lock_sync <= 2'h0;
        end
        else
        begin
            pd_sync   <= {pd_sync[0], pwr_down_i};
            dis_sync  <= {dis_sync[0], comp_disable_i};
            lock_sync <= {lock_sync[0], lock_en_i};
        end
    end

    assign unavail = pd_sync[1] | dis_sync[1];

    // ************************************************
    // transfer decode
    // ************************************************
    function automatic logic [3:0] word_idx(input logic [31:2] a);
        word_idx = a[dbp_pkg::ADDR_LSB +: dbp_pkg::REG_IDX_W];
    endfunction

    logic                           setup_cyc;
    logic                           access_cyc;
    logic                           external;
    logic                           locked;
    logic [dbp_pkg::WAIT_CNT_W-1:0] wait_cnt;
    logic [dbp_pkg::WAIT_CNT_W-1:0] wait_left;
    logic                           last_wait;
    logic                           ans_ready;
    logic                           ans_err;
    logic [31:0]                    ans_rdata;
    logic                           next_ready;
    logic                           next_err;
    logic [31:0]                    next_rdata;
    logic                           done;

    assign setup_cyc  = bus.dbg_bus_sel & ~bus.dbg_bus_enable;
    assign access_cyc = bus.dbg_bus_sel & bus.dbg_bus_enable;
    assign external   = ~bus.dbg_bus_addr[dbp_pkg::ADDR_SRC_BIT];
    // external writes blocked while lock active; reads still allowed
    assign locked     = external & lock_sync[1] & bus.dbg_bus_write;
    assign wait_left  = wait_cnt - 2'h1;
    assign last_wait  = (wait_left == dbp_pkg::WAIT_ZERO);
    assign done       = access_cyc & ans_ready;

    // ************************************************
    // wait-state counter
    // ************************************************
    // counts the stall cycles of an access
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wait_cnt <= dbp_pkg::WAIT_LOAD;
        else if (!access_cyc || ans_ready)
            wait_cnt <= dbp_pkg::WAIT_LOAD;
        else
            wait_cnt <= wait_left;
    end

    // ************************************************
    // register file
    // ************************************************
    logic [31:0] regs [dbp_pkg::REG_NUM];

    // side port loses to bus on same word
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < dbp_pkg::REG_NUM; i++)
                regs[i] <= dbp_pkg::REG_RESET;
        end
        else
        begin
            if (side_we_i)
                regs[side_idx_i] <= side_wdata_i;
            if (done && !ans_err && bus.dbg_bus_write && !locked)
                regs[word_idx(bus.dbg_bus_addr)] <= bus.dbg_bus_wdata;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            side_rdata_o <= dbp_pkg::REG_RESET;
        else
            side_rdata_o <= regs[side_idx_i];
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ext_access_o <= 1'b0;
            lock_hit_o   <= 1'b0;
        end
        else
        begin
            ext_access_o <= done & external;
            lock_hit_o   <= done & locked;
        end
    end

    // ************************************************
    // bus outputs
    // ************************************************
    // answer worked out one cycle ahead so that it leaves from flops;
    // costs nothing, as every access without an error response has its stall cycle anyway
    always_comb
    begin
        next_ready = dbp_pkg::READY_CLAMP;
        next_err   = 1'b0;
        next_rdata = dbp_pkg::RDATA_CLAMP;
        if (unavail && (setup_cyc || (access_cyc && !ans_ready)))
        begin
            next_err = dbp_pkg::ERR_CLAMP;
        end
        else if (setup_cyc || (access_cyc && !ans_ready && !last_wait))
        begin
            next_ready = 1'b0;
        end
        else if (access_cyc && !ans_ready && !bus.dbg_bus_write)
        begin
            // read data only in completing cycle
            next_rdata = regs[word_idx(bus.dbg_bus_addr)];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ans_ready <= dbp_pkg::READY_CLAMP;
            ans_err   <= 1'b0;
            ans_rdata <= dbp_pkg::RDATA_CLAMP;
        end
        else
        begin
            ans_ready <= next_ready;
            ans_err   <= next_err;
            ans_rdata <= next_rdata;
        end
    end

    assign bus.dbg_bus_ready = ans_ready;
    assign bus.dbg_bus_err   = ans_err;
    assign bus.dbg_bus_rdata = ans_rdata;
endmodule
`default_nettype wire

// file: logic/dbp_pkg.sv
// shared constants for the debug bus slave port and its master end
package dbp_pkg;
    localparam int          DATA_W      = 32;
    localparam int          ADDR_MSB    = 31;
    localparam int          ADDR_LSB    = 2;
    localparam int          REG_IDX_W   = 4;
    localparam int          REG_NUM     = 16;
    localparam logic [31:0] RDATA_CLAMP = 32'h0000_0000;
    localparam logic        READY_CLAMP = 1'b1;
    localparam logic        ERR_CLAMP   = 1'b1;
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam int          WAIT_CYCLES = 1;
    localparam int          WAIT_CNT_W  = 2;
    localparam logic [1:0]  WAIT_LOAD   = 2'h1;
    localparam logic [1:0]  WAIT_ZERO   = 2'h0;
    localparam int          ADDR_SRC_BIT = 31;

    typedef enum logic [1:0] {
        DBP_IDLE   = 2'b00,
        DBP_SETUP  = 2'b01,
        DBP_ACCESS = 2'b10
    } dbp_state_t;
endpackage

// file: logic/dbp_if.sv
// debug bus wires between the master end and the slave port
`timescale 1ns/100ps
`default_nettype none
interface dbp_if;
    logic [31:2] dbg_bus_addr;
    logic        dbg_bus_sel;
    logic        dbg_bus_enable;
    logic        dbg_bus_write;
    logic [31:0] dbg_bus_wdata;
    logic        dbg_bus_ready;
    logic [31:0] dbg_bus_rdata;
    logic        dbg_bus_err;

    modport master (
        output dbg_bus_addr,
        output dbg_bus_sel,
        output dbg_bus_enable,
        output dbg_bus_write,
        output dbg_bus_wdata,
        input  dbg_bus_ready,
        input  dbg_bus_rdata,
        input  dbg_bus_err
    );
    modport slave (
        input  dbg_bus_addr,
        input  dbg_bus_sel,
        input  dbg_bus_enable,
        input  dbg_bus_write,
        input  dbg_bus_wdata,
        output dbg_bus_ready,
        output dbg_bus_rdata,
        output dbg_bus_err
    );
endinterface
`default_nettype wire

// file: logic/dbp_master.sv
// debug bus master end: turns one user request into a bus transfer
`timescale 1ns/100ps
`default_nettype none
module dbp_master (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    dbp_if.master            bus,
    input  wire logic        req_i,
    input  wire logic        req_write_i,
    input  wire logic [31:2] req_addr_i,
    input  wire logic [31:0] req_wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic             err_o,
    output logic      [31:0] rdata_o
);
    dbp_pkg::dbp_state_t state;

    // ************************************************
    // transfer phasing
    // ************************************************
    // setup then access
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state              <= dbp_pkg::DBP_IDLE;
            bus.dbg_bus_sel    <= 1'b0;
            bus.dbg_bus_enable <= 1'b0;
            bus.dbg_bus_write  <= 1'b0;
            bus.dbg_bus_addr   <= 30'h0;
            bus.dbg_bus_wdata  <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                dbp_pkg::DBP_IDLE:
                begin
                    if (req_i)
                    begin
                        state             <= dbp_pkg::DBP_SETUP;
                        bus.dbg_bus_sel   <= 1'b1;
                        bus.dbg_bus_write <= req_write_i;
                        bus.dbg_bus_addr  <= req_addr_i;
                        bus.dbg_bus_wdata <= req_write_i ? req_wdata_i : 32'h0000_0000;
                    end
                end
                dbp_pkg::DBP_SETUP:
                begin
                    state              <= dbp_pkg::DBP_ACCESS;
                    bus.dbg_bus_enable <= 1'b1;
                end
                dbp_pkg::DBP_ACCESS:
                begin
                    if (bus.dbg_bus_ready)
                    begin
                        state              <= dbp_pkg::DBP_IDLE;
                        bus.dbg_bus_sel    <= 1'b0;
                        bus.dbg_bus_enable <= 1'b0;
                    end
                end
                default:
                begin
                    state              <= dbp_pkg::DBP_IDLE;
                    bus.dbg_bus_sel    <= 1'b0;
                    bus.dbg_bus_enable <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************
    // user-side answer
    // ************************************************
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            done_o  <= 1'b0;
            err_o   <= 1'b0;
            rdata_o <= 32'h0000_0000;
            busy_o  <= 1'b0;
        end
        else
        begin
            done_o <= (state == dbp_pkg::DBP_ACCESS) & bus.dbg_bus_ready;
            busy_o <= (state == dbp_pkg::DBP_IDLE) ? req_i
                    : !((state == dbp_pkg::DBP_ACCESS) & bus.dbg_bus_ready);
            if ((state == dbp_pkg::DBP_ACCESS) && bus.dbg_bus_ready)
            begin
                err_o <= bus.dbg_bus_err;
                if (!bus.dbg_bus_write)
                    rdata_o <= bus.dbg_bus_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/dbp_props.sv
// concurrent checks on the debug bus between master end and slave port
`timescale 1ns/100ps
`default_nettype none
module dbp_props (
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    input wire logic [31:2] dbg_bus_addr,
    input wire logic        dbg_bus_sel,
    input wire logic        dbg_bus_enable,
    input wire logic        dbg_bus_write,
    input wire logic [31:0] dbg_bus_wdata,
    input wire logic        dbg_bus_ready,
    input wire logic [31:0] dbg_bus_rdata,
    input wire logic        dbg_bus_err
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // ****************************************************************
    // protocol checks
    // ****************************************************************
    a_enable_needs_sel: assert property (
        dbg_bus_enable |-> dbg_bus_sel) else $error("enable without select");
    a_setup_one_cycle: assert property (
        dbg_bus_sel && !dbg_bus_enable |=> dbg_bus_sel && dbg_bus_enable)
        else $error("setup cycle not followed by access");
    a_ctrl_held_wait: assert property (
        dbg_bus_sel && dbg_bus_enable && !dbg_bus_ready |=> dbg_bus_enable
        && $stable(dbg_bus_addr) && $stable(dbg_bus_write) && $stable(dbg_bus_wdata))
        else $error("transfer changed during wait");
    a_one_wait_state: assert property (
        dbg_bus_sel && $rose(dbg_bus_enable) |-> !dbg_bus_ready || dbg_bus_err)
        else $error("no wait state in first access cycle");
    a_wait_bounded: assert property (
        dbg_bus_enable && !dbg_bus_ready |=> dbg_bus_ready)
        else $error("wait longer than one cycle");
    a_rdata_idle_zero: assert property (
        !(dbg_bus_sel && dbg_bus_enable && dbg_bus_ready && !dbg_bus_write)
        |-> dbg_bus_rdata == 32'h0000_0000) else $error("read data driven outside read");
    a_err_needs_sel: assert property (
        dbg_bus_err |-> dbg_bus_sel) else $error("error without select");
    a_err_clamp_ready: assert property (
        dbg_bus_err |-> dbg_bus_ready && dbg_bus_rdata == 32'h0000_0000)
        else $error("error without clamp levels");
    a_idle_between: assert property (
        dbg_bus_sel && dbg_bus_enable && dbg_bus_ready |=> !dbg_bus_sel)
        else $error("transfers pipelined");
    // ****************************************************************
    // scenario covers
    // ****************************************************************
    c_write_done: cover property (dbg_bus_enable && dbg_bus_ready && dbg_bus_write);
    c_read_done: cover property (dbg_bus_enable && dbg_bus_ready && !dbg_bus_write);
    c_err_done: cover property (dbg_bus_enable && dbg_bus_err);
endmodule
`default_nettype wire

// file: sim/test_debug_apb_slave_port.sv
// self-checking bench: master end and slave port joined by the debug bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_debug_apb_slave_port;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        pwr_down_i = 1'b0, comp_disable_i = 1'b0, lock_en_i = 1'b0;
    logic        side_we_i = 1'b0;
    logic [3:0]  side_idx_i = 4'h0;
    logic [31:0] side_wdata_i = 32'h0000_0000;
    logic [31:0] side_rdata_o, rdata_o;
    logic        ext_access_o, lock_hit_o, busy_o, done_o, err_o;
    logic        req_i = 1'b0, req_write_i = 1'b0;
    logic [31:2] req_addr_i = 30'h0000_0000;
    logic [31:0] req_wdata_i = 32'h0000_0000;
    int          err_count = 0;
    int          tests_run = 0;
    int          i;
    always #25 mclk_i = ~mclk_i;
    dbp_if bus ();
    dbp_slave dbp_slave_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bus),
        .pwr_down_i(pwr_down_i), .comp_disable_i(comp_disable_i), .side_we_i(side_we_i),
        .side_idx_i(side_idx_i), .side_wdata_i(side_wdata_i), .side_rdata_o(side_rdata_o),
        .ext_access_o(ext_access_o), .lock_hit_o(lock_hit_o), .lock_en_i(lock_en_i));
    dbp_master dbp_master_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bus),
        .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
        .rdata_o(rdata_o));
    dbp_props dbp_props_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .dbg_bus_addr(bus.dbg_bus_addr), .dbg_bus_sel(bus.dbg_bus_sel),
        .dbg_bus_enable(bus.dbg_bus_enable), .dbg_bus_write(bus.dbg_bus_write),
        .dbg_bus_wdata(bus.dbg_bus_wdata), .dbg_bus_ready(bus.dbg_bus_ready),
        .dbg_bus_rdata(bus.dbg_bus_rdata), .dbg_bus_err(bus.dbg_bus_err));
    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask
    // one bus transfer; read data is compared only on reads
    task automatic xfer(input logic w, input logic [31:2] a, input logic [31:0] d,
                        input logic exp_err);
        int n;
        n = 0;
        req_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        tick(1);
        req_i = 1'b0;
        `CHK(busy_o, 1'b1)
        while (done_o !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        `CHK(done_o, 1'b1)
        `CHK(err_o, exp_err)
        `CHK(busy_o, 1'b0)
        `CHK(ext_access_o, !a[31])
        `CHK(lock_hit_o, w && !a[31] && lock_en_i)
        if (!w)
            `CHK(rdata_o, d)
        tick(1);
    endtask
    task automatic side_wr(input logic [3:0] idx, input logic [31:0] d);
        side_we_i = 1'b1;
        side_idx_i = idx;
        side_wdata_i = d;
        tick(1);
        side_we_i = 1'b0;
        tick(1);
    endtask
    task automatic side_chk(input logic [3:0] idx, input logic [31:0] d);
        side_idx_i = idx;
        tick(2);
        `CHK(side_rdata_o, d)
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_count++;
        complete_run;
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        tick(10);
        arst_n_i = 1'b1;
        tick(1);
        xfer(1'b0, 30'h2000_0005, dbp_pkg::REG_RESET, 1'b0);
        for (i = 0; i < 16; i++)
            xfer(1'b1, {26'h200_0000, i[3:0]}, {16'hA5A5, 12'h000, i[3:0]}, 1'b0);
        for (i = 0; i < 16; i++)
            xfer(1'b0, {26'h200_0000, i[3:0]}, {16'hA5A5, 12'h000, i[3:0]}, 1'b0);
        xfer(1'b1, 30'h2000_0013, 32'hFFFF_0001, 1'b0);
        xfer(1'b0, 30'h0000_0003, 32'hFFFF_0001, 1'b0);
        $display("test read write done");
        side_wr(4'h7, 32'h1234_5678);
        xfer(1'b0, 30'h2000_0007, 32'h1234_5678, 1'b0);
        xfer(1'b1, 30'h2000_0008, 32'hCAFE_0008, 1'b0);
        side_chk(4'h8, 32'hCAFE_0008);
        $display("test side port done");
        lock_en_i = 1'b1;
        tick(3);
        xfer(1'b1, 30'h0000_0004, 32'hDEAD_0004, 1'b0);
        xfer(1'b0, 30'h0000_0004, 32'hA5A5_0004, 1'b0);
        xfer(1'b1, 30'h2000_0004, 32'hBEEF_0004, 1'b0);
        xfer(1'b0, 30'h0000_0004, 32'hBEEF_0004, 1'b0);
        lock_en_i = 1'b0;
        tick(3);
        xfer(1'b1, 30'h0000_0004, 32'h0000_0044, 1'b0);
        xfer(1'b0, 30'h2000_0004, 32'h0000_0044, 1'b0);
        $display("test lock done");
        for (i = 0; i < 2; i++)
        begin
            {pwr_down_i, comp_disable_i} = (i == 0) ? 2'b10 : 2'b01;
            tick(3);
            xfer(1'b1, 30'h2000_0001, 32'h5555_AAAA, dbp_pkg::ERR_CLAMP);
            xfer(1'b0, 30'h2000_0001, dbp_pkg::RDATA_CLAMP, dbp_pkg::ERR_CLAMP);
            {pwr_down_i, comp_disable_i} = 2'b00;
            tick(3);
            xfer(1'b0, 30'h2000_0001, 32'hA5A5_0001, 1'b0);
        end
        $display("test clamp done");
        tick(1);
        arst_n_i = 1'b0;
        tick(2);
        arst_n_i = 1'b1;
        tick(1);
        xfer(1'b0, 30'h2000_0002, dbp_pkg::REG_RESET, 1'b0);
        side_chk(4'h7, dbp_pkg::REG_RESET);
        $display("test second reset done");
        complete_run;
    end
endmodule
`default_nettype wire
